// ==== core/tsi_pkg.sv ====
package tsi_pkg;

  // host port
  localparam int          ADDR_W        = 13;
  localparam int          DATA_W        = 16;
  localparam logic [12:0] CM_LOW_BASE   = 13'h0000;
  localparam logic [12:0] CM_HIGH_BASE  = 13'h0800;
  localparam logic [12:0] CTRL_ADDR     = 13'h1000;
  localparam logic [12:0] IMS_ADDR      = 13'h1001;
  localparam logic [12:0] STATUS_ADDR   = 13'h1002;
  localparam logic [12:0] OUT_CTRL_BASE = 13'h1020;

  // control_reg fields
  localparam int          CTRL_BP_EN_BIT  = 3;
  localparam int          CTRL_VAR_EN_BIT = 4;
  localparam logic [15:0] CTRL_MASK       = 16'h0018;
  localparam logic [15:0] CTRL_RST        = 16'h0000;

  // internal_mode_reg fields
  localparam int          IMS_START_BIT = 0;
  localparam int          IMS_PAT_LSB   = 1;
  localparam logic [15:0] IMS_MASK      = 16'h000F;
  localparam logic [15:0] IMS_RST       = 16'h0000;

  // stream output control fields
  localparam int          OC_RATE_LSB = 0;
  localparam int          OC_ADV_LSB  = 9;
  localparam logic [15:0] OC_MASK     = 16'h0E03;
  localparam logic [15:0] OC_RST      = 16'h0000;
  localparam logic [1:0]  RATE_16M    = 2'h3;

  // conn_mem_low fields and high word mask
  localparam int          MSG_LSB    = 3;
  localparam int          CODE_LSB   = 1;
  localparam logic [1:0]  CODE_HIZ   = 2'h0;
  localparam logic [1:0]  CODE_MSG   = 2'h1;
  localparam logic [15:0] CM_HIGH_MASK = 16'h001F;

  // timing, idle byte and law conversion
  localparam int          VAR_MARGIN     = 7;
  localparam int          BP_FRAME_TICKS = 3;
  localparam logic [7:0]  IDLE_BYTE      = 8'hFF;
  localparam logic [7:0]  LAW_XOR        = 8'h55;

  typedef struct packed {
    logic       law_en;
    logic       var_sel;
    logic [4:0] src_stream;
    logic [7:0] src_chan;
    logic       entry_mode_sel;
  } cm_low_t;

  typedef struct packed {
    logic [1:0] spare;
    logic       voice;
    logic       in_law;
    logic       out_law;
  } cm_high_t;

  typedef struct packed {
    logic [12:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } host_req_t;

  typedef enum logic [2:0] {
    BP_IDLE = 3'b001,
    BP_FILL = 3'b010,
    BP_WAIT = 3'b100
  } bp_state_t;

endpackage : tsi_pkg

// ==== core/tdm_switch_connection_memory.sv ====
// Summary of operation
// R1: hiz output follows channel timing of its serial output stream by default.
// R2: non-16M streams advance hiz by 0, 1/4, 1/2, 3/4 or 4/4 bit.
// R3: 16M streams limit extra hiz advance to 0, 1/2 or 4/4 bit.
// R4: low-word bit 14 picks constant (0) or variable (1) delay.
// R5: variable delay sends output as early as possible, 7 channels to frame+7.
// R6: host sets global variable enable before choosing variable delay, else output invalid.
// R7: variable delay uses current or previous frame by n-m and stream compare.
// R8: constant delay is two frames plus output minus input channel.
// R9: constant delay stays usable while global variable enable is set.
// R10: each location holds a 16-bit low word and 5-bit high word.
// R11: with conversion enable clear, no law conversion and high word ignored.
// R12: every memory word read/written in one host access; unused bits read zero.
// R13: switching entries take source channel bits 8-1 and stream bits 13-9.
// R14: host writes high word before setting conversion enable.
// R15: message entries send bits 10-3; law conversion still applies.
// R16: host sets program enable, then pattern, then start bit.
// R17: block program writes pattern to low bits 2-0, clears everything else.
// R18: block program lasts at least two frame periods.
// R19: device clears the start bit when block programming completes.
// R20: host clears program enable itself after completion.
// R21: clearing start or enable aborts block programming at any time.
// R22: host writes zero to reserved high-word bits 15-5.
module tdm_switch_connection_memory
  import tsi_pkg::*;
#(
  parameter int STREAMS = 32,
  parameter int CHANS   = 64
)
(
  // clock and reset
  input  wire logic              CLOCK_IN,
  input  wire logic              RST_N_IN,
  // host register port
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [DATA_W-1:0] WR_DATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [DATA_W-1:0] RD_DATA_OUT,
  // serial tdm link
  input  wire logic              LINK_CLK_IN,
  input  wire logic              FRAME_IN,
  input  wire logic              SERIAL_IN_STREAM_IN,
  output logic                   SERIAL_OUT_STREAM_OUT,
  output logic                   SERIAL_OUT_STREAM_OE_OUT,
  output logic                   HIZ_CONTROL_OUT
);

  localparam int SW    = $clog2(STREAMS);
  localparam int CW    = $clog2(CHANS);
  localparam int AW    = SW + CW;
  localparam int SLOTS = STREAMS * CHANS;

  if (STREAMS > 32 || CHANS > 256 || (1 << SW) != STREAMS || (1 << CW) != CHANS
      || AW > 11 || SW < 1 || CW < 1)
  begin : g_bad_params
    $error("stream/channel counts must be powers of two within field widths");
  end

  host_req_t req;
  assign req = '{addr: ADDR_IN, wdata: WR_DATA_IN, wr: WR_IN, rd: RD_IN};

  // memories: no reset, software or block programming initialises cm_low and cm_high, serial input fills data_mem
  cm_low_t  cm_low   [SLOTS];  // R10
  cm_high_t cm_high  [SLOTS];  // R10
  logic [7:0] data_mem [3][SLOTS];

  // synchronisers, first stage read only by second
  logic lclk_s1, lclk_s2, lclk_d;
  logic fp_s1, fp_s2, din_s1, din_s2;

  // link state
  logic          fp_pend,   next_fp_pend;
  logic [2:0]    bit_cnt,   next_bit_cnt;
  logic [AW-1:0] slot,      next_slot;
  logic [1:0]    fbank,     next_fbank;
  logic [7:0]    in_shift,  next_in_shift;
  logic [7:0]    out_shift, next_out_shift;
  logic [7:0]    cyc,       next_cyc;
  logic [7:0]    bitlen,    next_bitlen;
  logic          hiz,       next_hiz;
  logic          ser_oe,    next_ser_oe;
  logic          frame_tick, next_frame_tick;

  // host side state
  logic [15:0]   ctrl,      next_ctrl;
  logic [15:0]   internal_mode_reg,       next_ims;
  logic [15:0]   out_ctrl   [STREAMS];
  logic [15:0]   next_out_ctrl [STREAMS];
  logic [15:0]   rdata,     next_rdata;
  bp_state_t     bp_state,  next_bp_state;
  logic [AW-1:0] bp_addr,   next_bp_addr;
  logic [1:0]    bp_frames, next_bp_frames;

  // memory write port
  logic          cm_we_low, cm_we_high;
  logic [AW-1:0] cm_waddr;
  logic [15:0]   cm_wlow;
  logic [4:0]    cm_whigh;

  logic rise, fall, var_en, bp_en, bp_start;
  assign rise     = lclk_s2 & ~lclk_d;
  assign fall     = ~lclk_s2 & lclk_d;
  assign var_en   = ctrl[CTRL_VAR_EN_BIT];
  assign bp_en    = ctrl[CTRL_BP_EN_BIT];
  assign bp_start = internal_mode_reg[IMS_START_BIT];

  function automatic logic [1:0] bank_back(input logic [1:0] b, input logic two);
    logic [1:0] r;
    r = (b == 2'h0) ? 2'h2 : b - 2'h1;
    if (two)
    begin
      r = (r == 2'h0) ? 2'h2 : r - 2'h1;
    end
    return r;
  endfunction : bank_back

  // byte sent in output slot s while bank b is being filled
  function automatic logic [7:0] slot_byte(input logic [AW-1:0] s, input logic [1:0] b);
    cm_low_t           e;
    cm_high_t          h;
    logic [15:0]       w;
    logic [AW-1:0]     src;
    logic signed [CW+1:0] diff;
    logic              cur;
    logic [7:0]        d;
    e    = cm_low[s];
    h    = cm_high[s];
    w    = e;
    src  = {e.src_chan[CW-1:0], e.src_stream[SW-1:0]};  // R13
    diff = $signed({2'b00, s[AW-1:SW]}) - $signed({2'b00, src[AW-1:SW]});
    cur  = (diff > VAR_MARGIN) || (diff == VAR_MARGIN && s[SW-1:0] >= src[SW-1:0]);  // R7
    if (e.entry_mode_sel)
    begin
      d = (w[CODE_LSB +: 2] == CODE_MSG) ? w[MSG_LSB +: 8] : IDLE_BYTE;  // R15
    end
    else if (e.var_sel)  // R4
    begin
      if (!var_en)
        d = IDLE_BYTE;  // R6
      else
        d = data_mem[cur ? b : bank_back(b, 1'b0)][src];  // R5 R7
    end
    else
    begin
      d = data_mem[bank_back(b, 1'b1)][src];  // R8 R9
    end
    // conversion only on voice entries whose laws differ; high word unused otherwise
    if (e.law_en && h.voice && (h.in_law != h.out_law))  // R11 R15
    begin
      d = d ^ LAW_XOR;
    end
    return d;
  endfunction : slot_byte

  function automatic logic slot_hiz(input logic [AW-1:0] s);
    logic [15:0] w;
    w = cm_low[s];
    return w[0] && (w[CODE_LSB +: 2] == CODE_HIZ);
  endfunction : slot_hiz

  // extra hiz advance in quarter bits for stream st
  function automatic logic [2:0] adv_quarters(input logic [SW-1:0] st);
    logic [15:0] oc;
    logic [2:0]  q;
    oc = out_ctrl[st];
    q  = (oc[OC_ADV_LSB +: 3] > 3'h4) ? 3'h4 : oc[OC_ADV_LSB +: 3];  // R2
    if (oc[OC_RATE_LSB +: 2] == RATE_16M)
    begin
      q = {q[2], q[1], 1'b0};  // R3
    end
    return q;
  endfunction : adv_quarters

  logic [AW-1:0] slot_after;
  logic [2:0]    adv_q;
  logic [7:0]    adv_pos;
  assign slot_after = slot + AW'(1);
  assign adv_pos    = bitlen - (8'(adv_q) * (bitlen >> 2));

  // process, not assign: the function reads out_ctrl, so a host write must re-trigger it
  always_comb
  begin
    adv_q = adv_quarters(slot_after[SW-1:0]);
  end

  always_comb
  begin
    next_fp_pend    = fp_pend;
    next_bit_cnt    = bit_cnt;
    next_slot       = slot;
    next_fbank      = fbank;
    next_in_shift   = in_shift;
    next_out_shift  = out_shift;
    next_cyc        = (cyc == 8'hFF) ? cyc : cyc + 8'h01;
    next_bitlen     = bitlen;
    next_hiz        = hiz;
    next_ser_oe     = ser_oe;
    next_frame_tick = 1'b0;
    if (rise)
    begin
      next_in_shift = {in_shift[6:0], din_s2};
      if (fp_s2)
      begin
        next_fp_pend = 1'b1;
      end
    end
    if (fall)
    begin
      next_cyc    = 8'h00;
      next_bitlen = cyc + 8'h01;
      if (fp_pend || bit_cnt == 3'h7)
      begin
        next_bit_cnt = 3'h0;
        if (fp_pend)
        begin
          next_slot       = '0;
          next_fbank      = (fbank == 2'h2) ? 2'h0 : fbank + 2'h1;
          next_fp_pend    = 1'b0;
          next_frame_tick = 1'b1;
        end
        else
        begin
          next_slot = slot_after;
        end
        next_out_shift = slot_byte(next_slot, next_fbank);
        next_hiz       = slot_hiz(next_slot);  // R1
        next_ser_oe    = ~slot_hiz(next_slot);
      end
      else
      begin
        next_bit_cnt   = bit_cnt + 3'h1;
        next_out_shift = {out_shift[6:0], 1'b0};
      end
    end
    else if (bit_cnt == 3'h7 && adv_q != 3'h0 && cyc == adv_pos)
    begin
      next_hiz = slot_hiz(slot_after);  // R2 R3
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    lclk_s1 <= LINK_CLK_IN;
    lclk_s2 <= lclk_s1;
    fp_s1   <= FRAME_IN;
    fp_s2   <= fp_s1;
    din_s1  <= SERIAL_IN_STREAM_IN;
    din_s2  <= din_s1;
    if (!RST_N_IN)
    begin
      lclk_d     <= 1'b0;
      fp_pend    <= 1'b0;
      bit_cnt    <= 3'h0;
      slot       <= '0;
      fbank      <= 2'h0;
      in_shift   <= 8'h00;
      out_shift  <= IDLE_BYTE;
      cyc        <= 8'h00;
      bitlen     <= 8'h08;
      hiz        <= 1'b1;
      ser_oe     <= 1'b0;
      frame_tick <= 1'b0;
    end
    else
    begin
      lclk_d     <= lclk_s2;
      fp_pend    <= next_fp_pend;
      bit_cnt    <= next_bit_cnt;
      slot       <= next_slot;
      fbank      <= next_fbank;
      in_shift   <= next_in_shift;
      out_shift  <= next_out_shift;
      cyc        <= next_cyc;
      bitlen     <= next_bitlen;
      hiz        <= next_hiz;
      ser_oe     <= next_ser_oe;
      frame_tick <= next_frame_tick;
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (rise && bit_cnt == 3'h7)
    begin
      data_mem[fbank][slot] <= {in_shift[6:0], din_s2};
    end
    if (cm_we_low)
    begin
      cm_low[cm_waddr] <= cm_wlow;
    end
    if (cm_we_high)
    begin
      cm_high[cm_waddr] <= cm_whigh;
    end
  end

  logic idx_ok, oc_hit;
  assign idx_ok = int'(req.addr[10:0]) < SLOTS;
  assign oc_hit = (req.addr[12:5] == OUT_CTRL_BASE[12:5]) && (int'(req.addr[4:0]) < STREAMS);

  always_comb
  begin
    next_ctrl      = ctrl;
    next_ims       = internal_mode_reg;
    next_out_ctrl  = out_ctrl;
    next_rdata     = 16'h0000;
    next_bp_state  = bp_state;
    next_bp_addr   = bp_addr;
    next_bp_frames = bp_frames;
    cm_we_low      = 1'b0;
    cm_we_high     = 1'b0;
    cm_waddr       = req.addr[AW-1:0];
    cm_wlow        = req.wdata;
    cm_whigh       = req.wdata[4:0];
    if (frame_tick && bp_frames != 2'h3)
    begin
      next_bp_frames = bp_frames + 2'h1;
    end
    unique case (bp_state)
      BP_IDLE:
      begin
        if (bp_en && bp_start)
        begin
          next_bp_state  = BP_FILL;
          next_bp_addr   = '0;
          next_bp_frames = 2'h0;
        end
      end
      BP_FILL:
      begin
        if (!bp_en || !bp_start)
        begin
          next_bp_state = BP_IDLE;  // R21
        end
        else
        begin
          cm_we_low  = 1'b1;
          cm_we_high = 1'b1;
          cm_waddr   = bp_addr;
          cm_wlow    = {13'h0000, internal_mode_reg[IMS_PAT_LSB +: 3]};  // R17
          cm_whigh   = 5'h00;  // R17
          next_bp_addr = bp_addr + AW'(1);
          if (bp_addr == AW'(SLOTS - 1))
          begin
            next_bp_state = BP_WAIT;
          end
        end
      end
      BP_WAIT:
      begin
        if (!bp_en || !bp_start)
        begin
          next_bp_state = BP_IDLE;  // R21
        end
        else if (int'(bp_frames) >= BP_FRAME_TICKS)  // R18
        begin
          next_ims[IMS_START_BIT] = 1'b0;  // R19
          next_bp_state           = BP_IDLE;
        end
      end
    endcase
    // host write after the self-clear so a same-cycle write wins; enable left to host
    if (req.wr)  // R12 R20
    begin
      if (req.addr[12] == 1'b0 && idx_ok && bp_state != BP_FILL)
      begin
        cm_we_low  = ~req.addr[11];
        cm_we_high = req.addr[11];
      end
      else if (req.addr == CTRL_ADDR)
        next_ctrl = req.wdata & CTRL_MASK;
      else if (req.addr == IMS_ADDR)
        next_ims = req.wdata & IMS_MASK;
      else if (oc_hit)
        next_out_ctrl[req.addr[SW-1:0]] = req.wdata & OC_MASK;
    end
    if (req.rd)  // R12
    begin
      if (req.addr[12] == 1'b0 && idx_ok)
        next_rdata = req.addr[11] ? {11'h000, cm_high[req.addr[AW-1:0]]}
                                  : cm_low[req.addr[AW-1:0]];
      else if (req.addr == CTRL_ADDR)
        next_rdata = ctrl;
      else if (req.addr == IMS_ADDR)
        next_rdata = internal_mode_reg;
      else if (req.addr == STATUS_ADDR)
        next_rdata = {13'h0000, bp_state != BP_IDLE, fbank};
      else if (oc_hit)
        next_rdata = out_ctrl[req.addr[SW-1:0]];
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!RST_N_IN)
    begin
      ctrl      <= CTRL_RST;
      internal_mode_reg       <= IMS_RST;
      rdata     <= 16'h0000;
      bp_state  <= BP_IDLE;
      bp_addr   <= '0;
      bp_frames <= 2'h0;
      for (int i = 0; i < STREAMS; i++)
      begin
        out_ctrl[i] <= OC_RST;
      end
    end
    else
    begin
      ctrl      <= next_ctrl;
      internal_mode_reg       <= next_ims;
      rdata     <= next_rdata;
      bp_state  <= next_bp_state;
      bp_addr   <= next_bp_addr;
      bp_frames <= next_bp_frames;
      out_ctrl  <= next_out_ctrl;
    end
  end

  assign RD_DATA_OUT              = rdata;
  assign SERIAL_OUT_STREAM_OUT    = out_shift[7];
  assign SERIAL_OUT_STREAM_OE_OUT = ser_oe;
  assign HIZ_CONTROL_OUT          = hiz;

endmodule : tdm_switch_connection_memory

// ==== verification/tdm_switch_connection_memory_properties.sv ====
module tdm_switch_props
  import tsi_pkg::*;
#(
  parameter int STREAMS = 32,
  parameter int CHANS   = 64
)
(
  // watched ports
  input wire logic              CLOCK_IN,
  input wire logic              RST_N_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [DATA_W-1:0] WR_DATA_IN,
  input wire logic              WR_IN,
  input wire logic              RD_IN,
  input wire logic [DATA_W-1:0] RD_DATA_OUT,
  input wire logic              SERIAL_OUT_STREAM_OE_OUT,
  input wire logic              HIZ_CONTROL_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lead;
  logic [7:0] next_lead;
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  // cycles the hiz flag runs ahead of a slot still driven
  always_comb
  begin
    next_lead = 8'h00;
    if (RST_N_IN && HIZ_CONTROL_OUT && SERIAL_OUT_STREAM_OE_OUT)
    begin
      next_lead = lead + 8'h01;
    end
  end
  always_ff @(posedge CLOCK_IN)
  begin
    lead <= next_lead;
  end
  sequence s_ctrl_wr;
    WR_IN && ADDR_IN == CTRL_ADDR;
  endsequence
  sequence s_ctrl_rd;
    RD_IN && ADDR_IN == CTRL_ADDR;
  endsequence
  a_ctrl_readback: assert property (s_ctrl_wr ##2 s_ctrl_rd |=>
    RD_DATA_OUT == ($past(WR_DATA_IN, 3) & CTRL_MASK)) else $error("control readback");
  a_rd_quiet: assert property (!RD_IN |=> RD_DATA_OUT == 16'h0000)
    else $error("read data outside slot");
  a_high_word_mask: assert property (
    RD_IN && ADDR_IN >= CM_HIGH_BASE && ADDR_IN < CTRL_ADDR |=> RD_DATA_OUT[15:5] == 11'h000)
    else $error("high word spare bits");
  a_ims_mask: assert property (
    RD_IN && ADDR_IN == IMS_ADDR |=> RD_DATA_OUT[15:4] == 12'h000)
    else $error("mode reg spare bits");
  a_unmapped_zero: assert property (
    RD_IN && ADDR_IN == 13'h1FFF |=> RD_DATA_OUT == 16'h0000)
    else $error("unmapped read nonzero");
  a_hiz_on_order: assert property ($rose(SERIAL_OUT_STREAM_OE_OUT) |-> !HIZ_CONTROL_OUT)
    else $error("hiz late at slot start");
  a_hiz_off_order: assert property ($fell(SERIAL_OUT_STREAM_OE_OUT) |-> HIZ_CONTROL_OUT)
    else $error("hiz late at slot end");
  // bench link bit is 8 cycles, so a full bit of advance is the most
  a_hiz_lead_max: assert property (lead <= 8'h09)
    else $error("hiz advance too long");
endmodule : tdm_switch_props

bind tdm_switch_connection_memory tdm_switch_props #(.STREAMS(STREAMS), .CHANS(CHANS)) u_props (
  .CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN), .WR_DATA_IN(WR_DATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RD_DATA_OUT(RD_DATA_OUT),
  .SERIAL_OUT_STREAM_OE_OUT(SERIAL_OUT_STREAM_OE_OUT), .HIZ_CONTROL_OUT(HIZ_CONTROL_OUT));

// ==== verification/tdm_far_end.sv ====
module tdm_far_end #(
  parameter int STREAMS = 2,
  parameter int CHANS   = 16
)
(
  // serial link
  output logic      link_clk_out,
  output logic      frame_out,
  output logic      data_out,
  input  wire logic ser_in,
  input  wire logic oe_in
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SL = STREAMS * CHANS;
  int         bitcnt = SL * 8 - 2;
  logic [2:0] fcnt = 3'h0;
  logic [7:0] tx;
  logic [7:0] sh;
  logic [7:0] rx [SL];
  logic [2:0] rxf [SL];
  logic       rxoe [SL];
  // free running bit clock, phase unrelated to the system clock
  initial
  begin
    link_clk_out = 1'b0;
    frame_out = 1'b0;
    data_out = 1'b1;
    #137;
    forever #200 link_clk_out = ~link_clk_out;
  end
  // each slot carries frame count and its own index
  always @(negedge link_clk_out)
  begin
    bitcnt = (bitcnt + 1) % (SL * 8);
    if (bitcnt == 0)
      fcnt = fcnt + 3'h1;
    tx = {fcnt, 5'(bitcnt / 8)};
    frame_out <= (bitcnt == SL * 8 - 1);
    data_out <= tx[7 - bitcnt % 8];
  end
  always @(posedge link_clk_out)
  begin
    sh = {sh[6:0], ser_in};
    if (bitcnt % 8 == 7)
    begin
      rx[bitcnt / 8] = sh;
      rxf[bitcnt / 8] = fcnt;
      rxoe[bitcnt / 8] = oe_in;
    end
  end
endmodule : tdm_far_end

// ==== verification/test_tdm_switch_connection_memory.sv ====
module test_tdm_switch_connection_memory
  import tsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FR = 2048;
  logic        clk = 1'b0;
  logic        rst_n, wr, rd, sout, soe, hiz, link, frm, sin, soe_q;
  logic [12:0] addr;
  logic [15:0] wdata, rdata;
  int          fail_count = 0;
  int          tests_run = 0;
  int          lead = 0;
  int          last_lead = 0;
  int os[6] = '{18, 6, 17, 16, 4, 29};
  int ms[6] = '{2, 7, 2, 3, 5, 10};
  int vs[6] = '{1, 1, 1, 1, 0, 0};
  int dv[6] = '{0, 1, 0, 1, 2, 2};
  int rt[6] = '{0, 0, 0, 0, 0, 3};
  int qv[6] = '{0, 1, 2, 3, 4, 2};

  always #25 clk = ~clk;

  tdm_switch_connection_memory #(.STREAMS(2), .CHANS(16)) u_dut (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WR_DATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RD_DATA_OUT(rdata), .LINK_CLK_IN(link),
    .FRAME_IN(frm), .SERIAL_IN_STREAM_IN(sin), .SERIAL_OUT_STREAM_OUT(sout),
    .SERIAL_OUT_STREAM_OE_OUT(soe), .HIZ_CONTROL_OUT(hiz));

  tdm_far_end #(.STREAMS(2), .CHANS(16)) u_far (
    .link_clk_out(link), .frame_out(frm), .data_out(sin), .ser_in(sout), .oe_in(soe));

  // cycles hiz is up while the slot is still driven
  always @(posedge clk)
  begin
    soe_q <= soe;
    lead <= (soe === 1'b1 && hiz === 1'b1) ? lead + 1 : 0;
    if (soe_q === 1'b1 && soe === 1'b0)
      last_lead <= lead;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic wr_reg(input logic [12:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [12:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [12:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd_reg(a, d);
    chk(d, e);
  endtask : rd_chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (90000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  initial
  begin
    logic [15:0] d;
    time         t0;
    rst_n = 1'b0;
    addr = 13'h0000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    repeat (8) @(posedge clk);
    #1 chk({14'h0000, hiz, soe}, 16'h0002);
    @(posedge clk);
    rst_n <= 1'b1;
    wr_reg(CTRL_ADDR, 16'hFFE7);
    rd_chk(CTRL_ADDR, 16'h0000);
    wr_reg(CM_HIGH_BASE + 13'd31, 16'h001F);
    rd_chk(CM_HIGH_BASE + 13'd31, 16'h001F);
    wr_reg(CM_LOW_BASE + 13'd31, 16'hBEEF);
    rd_chk(CM_LOW_BASE + 13'd31, 16'hBEEF);
    wr_reg(13'h1FFF, 16'h1234);
    rd_chk(13'h1FFF, 16'h0000);
    $display("registers done");
    // abort by start bit, then by enable bit
    wr_reg(CTRL_ADDR, 16'h0018);
    wr_reg(IMS_ADDR, 16'h0004);
    wr_reg(IMS_ADDR, 16'h0005);
    wr_reg(IMS_ADDR, 16'h0004);
    rd_reg(STATUS_ADDR, d);
    chk(d & 16'h0004, 16'h0000);
    wr_reg(IMS_ADDR, 16'h0005);
    wr_reg(CTRL_ADDR, 16'h0010);
    rd_reg(STATUS_ADDR, d);
    chk(d & 16'h0004, 16'h0000);
    wr_reg(IMS_ADDR, 16'h0004);
    rd_chk(CM_LOW_BASE + 13'd31, 16'hBEEF);
    $display("abort done");
    wr_reg(CTRL_ADDR, 16'h0018);
    wr_reg(IMS_ADDR, 16'h0002);
    wr_reg(IMS_ADDR, 16'h0003);
    t0 = $time;
    rd_reg(STATUS_ADDR, d);
    chk(d & 16'h0004, 16'h0004);
    // status bit 0 is a bank bit, not the start bit: force the first poll
    d = 16'h0001;
    for (int i = 0; i < 5000 && d[0] !== 1'b0; i++)
      rd_reg(IMS_ADDR, d);
    chk(d & 16'h0001, 16'h0000);
    chk(16'(($time - t0) >= 2 * FR * 50), 16'h0001);
    rd_chk(CM_LOW_BASE + 13'd31, 16'h0001);
    rd_chk(CM_HIGH_BASE + 13'd31, 16'h0000);
    wr_reg(CTRL_ADDR, 16'h0010);
    $display("block program done");
    // all slots hiz now; three message slots
    wr_reg(CM_LOW_BASE + 13'd10, 16'h052B);
    wr_reg(CM_HIGH_BASE + 13'd11, 16'h0005);
    wr_reg(CM_LOW_BASE + 13'd11, 16'h852B);
    wr_reg(CM_HIGH_BASE + 13'd12, 16'h0005);
    wr_reg(CM_LOW_BASE + 13'd12, 16'h052B);
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(OUT_CTRL_BASE, 16'(qv[i] << 9 | rt[i]));
      wr_reg(OUT_CTRL_BASE + 13'd1, 16'(qv[i] << 9 | rt[i]));
      repeat (2 * FR) @(posedge clk);
      chk(16'(last_lead >= 2 * qv[i] - 1 && last_lead <= 2 * qv[i] + 1), 16'h0001);
    end
    wr_reg(OUT_CTRL_BASE, 16'h0000);
    wr_reg(OUT_CTRL_BASE + 13'd1, 16'h0000);
    $display("hiz advance done");
    for (int i = 0; i < 6; i++)
      wr_reg(CM_LOW_BASE + 13'(os[i]), {1'b0, 1'(vs[i]), 5'(ms[i] % 2), 8'(ms[i] / 2), 1'b0});
    repeat (3 * FR) @(posedge clk);
    chk({7'h00, u_far.rxoe[10], u_far.rx[10]}, 16'h01A5);
    chk({8'h00, u_far.rx[11]}, 16'h00F0);
    chk({8'h00, u_far.rx[12]}, 16'h00A5);
    chk({15'h0000, u_far.rxoe[13]}, 16'h0000);
    for (int i = 0; i < 6; i++)
      chk({7'h00, u_far.rxoe[os[i]], u_far.rx[os[i]]},
          {7'h00, 1'b1, 3'(u_far.rxf[os[i]] - 3'(dv[i])), 5'(ms[i])});
    $display("switching done");
    finish_test();
  end
endmodule : test_tdm_switch_connection_memory
